//--- hw/dual_dac_pkg.sv
// constants shared by both ends of the dual channel converter serial link
// assumes a 40 MHz system clock on both ends
`default_nettype none
package dual_dac_pkg;
   localparam int          WORD_BITS      = 16;
   localparam int          DATA_BITS      = 12;
   localparam int          SEL_POS        = 12;
   localparam logic [4:0]  BIT_COUNT_LAST = 5'h10;
   localparam logic [11:0] LATCH_RESET    = 12'h000;
   localparam logic [15:0] SHIFT_RESET    = 16'h0000;
   // system clock period and link clock half period
   localparam int          SYS_CLK_NS     = 25;
   localparam int          SCLK_HALF_NS   = 100;
   localparam int          SCLK_HALF_CYC  = (SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam logic [3:0]  SCLK_HALF_Q    = 4'(SCLK_HALF_CYC - 1);
endpackage
`default_nettype wire

//--- hw/dual_dac_link_if.sv
// three wire serial link plus load strobe and clear between host and converter
// assumes both ends on sys_clk domain; link pins are plain levels
`default_nettype none
interface dual_dac_link_if;
   logic serial_clock;
   logic serial_data_in;
   logic frame_sync_n;
   logic load_latch_n;
   logic clear_n;
   modport device (input serial_clock, serial_data_in, frame_sync_n, load_latch_n, clear_n);
   modport host   (output serial_clock, serial_data_in, frame_sync_n, load_latch_n, clear_n);
endinterface
`default_nettype wire

//--- hw/dual_dac_device.sv
// serial loader of the dual channel converter: shift register and two latches
// assumes link pins asynchronous to sys_clk_i; they are synchronised here
`default_nettype none
// Summary of operation
// (R1) one shared shift register, two latches
// (R2) sample a bit per falling clock edge
// (R3) counter stops shifting after 16 bits
// (R4) host raises sync after full word
// (R5) thirteenth bit selects channel A or B
// (R6) only last 12 bits reach latch
// (R7) host sends three spare, select, data MSB first
// (R8) load strobe level sampled at sync fall
// (R9) strobe low: update on sixteenth edge
// (R10) strobe high: update on strobe falling edge
// (R11) host raises strobe before next frame
// (R12) sync falling restarts the shift logic
// (R13) clear empties shift register, zeroes latches
// (R14) unselected latch keeps its contents
// (R15) strobed mode holds word until strobe
module dual_dac_device (
   // system
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        clk_en_i,
   // link
   dual_dac_link_if.device  link,
   // channel latch contents
   output logic [11:0]      latch_a_o,
   output logic [11:0]      latch_b_o
);
   ////////////////////////////////////////////////////////////////////////////
   // pin positions inside the synchroniser vector
   localparam int         PIN_COUNT = 5;
   localparam int         PIN_SCLK  = 0;
   localparam int         PIN_DATA  = 1;
   localparam int         PIN_SYNC  = 2;
   localparam int         PIN_LOAD  = 3;
   localparam int         PIN_CLEAR = 4;
   // level each pin rests at while idle: data low, every other pin high,
   // so no false edge is seen when reset is let go
   localparam logic [4:0] PIN_IDLE  = 5'h1d;

   // raw pins, synchronised levels and their copies one cycle older
   logic [4:0]  pins_raw;
   wire  [4:0]  pin_now;
   wire  [4:0]  pin_old;
   // shift register, bit counter and update mode
   logic [15:0] shift_q;
   logic [4:0]  count_q;
   logic        auto_q;
   logic        pending_q;
   // decoded link events and levels; the edge events are valid for one enabled system clock
   logic        sclk_fall;
   logic        sync_fall;
   logic        load_fall;
   logic        clear_req;
   logic        in_frame;
   logic        can_shift;
   logic        last_bit;
   // word as it stands once the current bit is shifted in
   logic [15:0] word_d;
   // latch load request and the word it takes its bits from
   logic        auto_load;
   logic        strobe_load;
   logic        any_load;
   logic [15:0] load_word;

   ////////////////////////////////////////////////////////////////////////////
   // a synchronised pin that was high one cycle ago and is low now
   function automatic logic went_low(input logic was, input logic now);
      return was & ~now;
   endfunction

   // bit 12 of a received word picks channel B when set, A when clear
   function automatic logic picks_b(input logic [15:0] word);
      return word[dual_dac_pkg::SEL_POS];
   endfunction

   // the twelve data bits of a word; the four leading bits never reach a latch
   function automatic logic [11:0] data_of(input logic [15:0] word);
      return word[dual_dac_pkg::DATA_BITS-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // every link pin arrives unrelated to sys_clk_i
   assign pins_raw = {link.clear_n, link.load_latch_n, link.frame_sync_n,
                      link.serial_data_in, link.serial_clock};

   // two flip-flops per pin, then one more stage for edge finding; only the
   // second stage and the stage behind it are read, never the first
   for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      logic meta_q;
      logic sync_q;
      logic old_q;
      always_ff @(posedge sys_clk_i) begin
         if (rst_i) begin
            meta_q <= PIN_IDLE[i];
            sync_q <= PIN_IDLE[i];
            old_q  <= PIN_IDLE[i];
         end else if (clk_en_i) begin
            meta_q <= pins_raw[i];
            sync_q <= meta_q;
            old_q  <= sync_q;
         end
      end
      assign pin_now[i] = sync_q;
      assign pin_old[i] = old_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // link events; each edge event lasts exactly one enabled system clock, clear_req follows the clear level
   assign sclk_fall = went_low(pin_old[PIN_SCLK], pin_now[PIN_SCLK]);
   assign sync_fall = went_low(pin_old[PIN_SYNC], pin_now[PIN_SYNC]);
   assign load_fall = went_low(pin_old[PIN_LOAD], pin_now[PIN_LOAD]);
   assign clear_req = ~pin_now[PIN_CLEAR];
   // the cycle of the sync fall belongs to the restart, not to the frame
   assign in_frame  = ~pin_now[PIN_SYNC] & ~sync_fall;
   // shifting stops once the counter has reached sixteen
   assign can_shift = in_frame & sclk_fall & (count_q != dual_dac_pkg::BIT_COUNT_LAST);
   assign last_bit  = can_shift & (count_q == dual_dac_pkg::BIT_COUNT_LAST - 5'h1);
   // data bit is taken from the same synchroniser depth as the clock, so the
   // level seen is the one the host set half a link period before the fall
   assign word_d    = {shift_q[14:0], pin_now[PIN_DATA]};

   ////////////////////////////////////////////////////////////////////////////
   // shared shift register: one bit per falling link clock inside a frame
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         shift_q <= dual_dac_pkg::SHIFT_RESET;
      end else if (clk_en_i) begin
         if (clear_req) begin
            shift_q <= dual_dac_pkg::SHIFT_RESET;               // see (R13)
         end else if (can_shift) begin
            shift_q <= word_d;                                  // see (R2) (R1)
         end
      end
   end

   // bit counter: a sync fall restarts it, sixteen shifts park it so that
   // later pulses of a free running link clock do nothing
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         count_q <= dual_dac_pkg::BIT_COUNT_LAST;
      end else if (clk_en_i) begin
         if (clear_req) begin
            count_q <= dual_dac_pkg::BIT_COUNT_LAST;
         end else if (sync_fall) begin
            count_q <= 5'h0;                                    // see (R12)
         end else if (can_shift) begin
            count_q <= count_q + 5'h1;                          // see (R3)
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // update mode: the strobe level at the sync fall picks it for the frame
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         auto_q <= 1'b0;
      end else if (clk_en_i) begin
         if (clear_req) begin
            auto_q <= 1'b0;
         end else if (sync_fall) begin
            auto_q <= ~pin_now[PIN_LOAD];                       // see (R8)
         end
      end
   end

   // strobed word waiting for its strobe; a strobe fall with no complete word
   // behind it is ignored, and the last bit wins over a strobe in one cycle
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pending_q <= 1'b0;
      end else if (clk_en_i) begin
         if (clear_req || sync_fall) begin
            pending_q <= 1'b0;
         end else if (last_bit && !auto_q) begin
            pending_q <= 1'b1;                                  // see (R15)
         end else if (load_fall) begin
            pending_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // a latch loads either on the last bit in automatic mode or on the strobe
   // fall in strobed mode; in strobed mode the word is read from the shift
   // register, which holds still until the next sync fall
   assign auto_load   = last_bit & auto_q;                      // see (R9)
   assign strobe_load = pending_q & load_fall;                  // see (R10) (R15)
   assign any_load    = auto_load | strobe_load;
   assign load_word   = auto_load ? word_d : shift_q;

   // channel A latch: loads only when the select bit is clear
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         latch_a_o <= dual_dac_pkg::LATCH_RESET;
      end else if (clk_en_i) begin
         if (clear_req) begin
            latch_a_o <= dual_dac_pkg::LATCH_RESET;             // see (R13)
         end else if (any_load && !picks_b(load_word)) begin    // see (R5)
            latch_a_o <= data_of(load_word);                    // see (R6)
         end
      end
   end

   // channel B latch: loads only when the select bit is set; a load meant for
   // the other channel leaves it untouched
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         latch_b_o <= dual_dac_pkg::LATCH_RESET;
      end else if (clk_en_i) begin
         if (clear_req) begin
            latch_b_o <= dual_dac_pkg::LATCH_RESET;             // see (R13)
         end else if (any_load && picks_b(load_word)) begin     // see (R5)
            latch_b_o <= data_of(load_word);                    // see (R14)
         end
      end
   end
endmodule
`default_nettype wire

//--- hw/dual_dac_host.sv
// host end: sends one 16 bit frame per request, manual or automatic update
// assumes requests come from logic on sys_clk_i
`default_nettype none
module dual_dac_host (
   // system
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        clk_en_i,
   // request
   input  wire logic        start_i,
   input  wire logic        channel_i,
   input  wire logic [11:0] data_i,
   input  wire logic        strobed_i,
   input  wire logic        clear_i,
   output logic             busy_o,
   // link
   dual_dac_link_if.host    link
);
   typedef enum logic [2:0] {IDLE, SETUP, HIGH, LOW, STROBE, DONE} state_t;
   state_t      state_q;
   logic [3:0]  div_q;
   logic [15:0] word_q;
   logic [4:0]  left_q;
   logic        strobed_q;
   wire         tick = (div_q == dual_dac_pkg::SCLK_HALF_Q);

   ////////////////////////////////////////////////////////////////////////////
   // clock divider for half periods
   always_ff @(posedge sys_clk_i) begin
      if (rst_i)
         div_q <= 4'h0;
      else if (clk_en_i)
         div_q <= (tick || state_q == IDLE) ? 4'h0 : div_q + 4'h1;
   end

   // frame sequencer
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q             <= IDLE;
         word_q              <= 16'h0000;
         left_q              <= 5'h0;
         strobed_q           <= 1'b0;
         busy_o              <= 1'b0;
         link.serial_clock   <= 1'b1;
         link.serial_data_in <= 1'b0;
         link.frame_sync_n   <= 1'b1;
         link.load_latch_n   <= 1'b1;
         link.clear_n        <= 1'b1;
      end else if (clk_en_i) begin
         link.clear_n <= ~clear_i;
         unique case (state_q)
            IDLE: if (start_i) begin
               word_q            <= {3'h0, channel_i, data_i};  // see (R7)
               strobed_q         <= strobed_i;
               left_q            <= dual_dac_pkg::BIT_COUNT_LAST;
               link.load_latch_n <= strobed_i;                  // see (R11) (R8)
               busy_o            <= 1'b1;
               state_q           <= SETUP;
            end
            SETUP: if (tick) begin
               link.frame_sync_n   <= 1'b0;
               link.serial_data_in <= word_q[15];
               state_q             <= HIGH;
            end
            HIGH: if (tick) begin
               link.serial_clock <= 1'b0;                       // see (R2)
               word_q            <= {word_q[14:0], 1'b0};
               left_q            <= left_q - 5'h1;
               state_q           <= LOW;
            end
            LOW: if (tick) begin
               link.serial_clock <= 1'b1;
               if (left_q == 5'h0) begin
                  link.frame_sync_n <= 1'b1;                    // see (R4)
                  state_q           <= strobed_q ? STROBE : DONE;
               end else begin
                  link.serial_data_in <= word_q[15];
                  state_q             <= HIGH;
               end
            end
            STROBE: if (tick) begin
               link.load_latch_n <= 1'b0;                       // see (R10)
               state_q           <= DONE;
            end
            DONE: if (tick) begin
               link.load_latch_n <= 1'b1;                       // see (R11)
               busy_o            <= 1'b0;
               state_q           <= IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- testbench/dual_dac_assertions.sv
// checker for the link between the host end and the converter end
// assumes link wires are driven from registers on sys_clk_i
`default_nettype none
module dual_dac_assertions (
   // system
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   // link
   input wire logic        serial_clock,
   input wire logic        serial_data_in,
   input wire logic        frame_sync_n,
   input wire logic        load_latch_n,
   input wire logic        clear_n,
   // channel latches
   input wire logic [11:0] latch_a_o,
   input wire logic [11:0] latch_b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic       sclk_q;
   logic       sync_q;
   logic [4:0] falls_q;
   logic       strobed_q;
   ////////////////////////////////////////////////////////////////////////////////
   // previous link levels for edge finding
   always_ff @(posedge sys_clk_i) begin
      sclk_q <= serial_clock;
      sync_q <= frame_sync_n;
   end
   // falling link clock edges seen in the current frame
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || (sync_q && !frame_sync_n)) begin
         falls_q <= 5'h00;
      end else if (sclk_q && !serial_clock && !frame_sync_n) begin
         falls_q <= falls_q + 5'h01;
      end
   end
   // strobed word pending: loaded from the strobe level at frame start, dropped once the strobe is low
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || (sync_q && !frame_sync_n)) begin
         strobed_q <= load_latch_n;
      end else if (!load_latch_n) begin
         strobed_q <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   clk_idle_a: assert property (frame_sync_n |-> serial_clock)
      else $error("link clock low outside a frame");
   data_hold_a: assert property ($fell(serial_clock) |-> $stable(serial_data_in))
      else $error("data moved at the sampling edge");
   word_done_a: assert property ($rose(frame_sync_n) |-> falls_q == 5'h10)
      else $error("frame ended before sixteen bits");
   load_outside_a: assert property ($fell(load_latch_n) |-> frame_sync_n)
      else $error("strobe fell inside a frame");
   one_latch_a: assert property ($changed(latch_a_o) && $changed(latch_b_o) |->
      latch_a_o == 12'h000 && latch_b_o == 12'h000)
      else $error("both latches changed in one update");
   clear_zero_a: assert property ($fell(clear_n) |->
      ##[1:6] latch_a_o == 12'h000 && latch_b_o == 12'h000)
      else $error("clear did not zero the latches");
   frame_gate_a: assert property (($changed(latch_a_o) || $changed(latch_b_o)) && clear_n
      |-> falls_q == 5'h10)
      else $error("latch changed before a full word");
   auto_load_a: assert property (sclk_q && !serial_clock && !frame_sync_n &&
      falls_q == 5'h0f && !strobed_q |-> ##[1:8] ($changed(latch_a_o) || $changed(latch_b_o)))
      else $error("no update after the last bit");
   strobe_load_a: assert property ($fell(load_latch_n) && strobed_q && falls_q == 5'h10
      |-> ##[1:8] ($changed(latch_a_o) || $changed(latch_b_o)))
      else $error("no update after the strobe");
   auto_seen_c: cover property ($rose(frame_sync_n) && !strobed_q);
   strobe_seen_c: cover property ($fell(load_latch_n) && strobed_q);
   clear_seen_c: cover property ($fell(clear_n));
endmodule
`default_nettype wire

//--- testbench/tb_dual_dac_serial_loader.sv
// self-checking bench: the host end loads the converter end across the link
// assumes the host sends a whole frame for one start request
`default_nettype none
module tb_dual_dac_serial_loader;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk_i;
   logic        rst_i;
   logic        clk_en_i;
   logic        start_i;
   logic        channel_i;
   logic        strobed_i;
   logic        clear_i;
   logic        busy_o;
   logic [11:0] data_i;
   logic [11:0] latch_a_o;
   logic [11:0] latch_b_o;
   logic [11:0] exp_a;
   logic [11:0] exp_b;
   int          bad_count = 0;
   int          n_checks = 0;
   int          cycles = 0;
   dual_dac_link_if link ();
   dual_dac_host i_dual_dac_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
      .start_i(start_i), .channel_i(channel_i), .data_i(data_i), .strobed_i(strobed_i),
      .clear_i(clear_i), .busy_o(busy_o), .link(link));
   dual_dac_device i_dual_dac_device (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
      .link(link), .latch_a_o(latch_a_o), .latch_b_o(latch_b_o));
   dual_dac_assertions i_dual_dac_assertions (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .serial_clock(link.serial_clock), .serial_data_in(link.serial_data_in),
      .frame_sync_n(link.frame_sync_n), .load_latch_n(link.load_latch_n),
      .clear_n(link.clear_n), .latch_a_o(latch_a_o), .latch_b_o(latch_b_o));
   ////////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] want);
      n_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask
   // closing report
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one frame through the host, then both latches compared
   task automatic send(input logic ch, input logic [11:0] data, input logic strb);
      int n;
      @(posedge sys_clk_i) #2;
      start_i   = 1'b1;
      channel_i = ch;
      data_i    = data;
      strobed_i = strb;
      @(posedge sys_clk_i) #2;
      start_i = 1'b0;
      n = 0;
      while (busy_o !== 1'b0 && n < 400) begin
         @(posedge sys_clk_i) #2;
         n++;
         // strobed sends freeze both ends together for three cycles mid frame
         clk_en_i = !(strb && n >= 20 && n < 23);
      end
      repeat (8) @(posedge sys_clk_i);
      #2;
      if (ch)
         exp_b = data;
      else
         exp_a = data;
      check("latch_a", latch_a_o, exp_a);
      check("latch_b", latch_b_o, exp_b);
      check("busy", {11'h000, busy_o}, 12'h000);
      check("load_latch_n", {11'h000, link.load_latch_n}, 12'h001);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang limit
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         give_verdict();
      end
   end
   // main sequence
   initial begin
      rst_i     = 1'b1;
      clk_en_i  = 1'b1;
      start_i   = 1'b0;
      channel_i = 1'b0;
      strobed_i = 1'b0;
      clear_i   = 1'b0;
      data_i    = 12'h000;
      exp_a     = dual_dac_pkg::LATCH_RESET;
      exp_b     = dual_dac_pkg::LATCH_RESET;
      repeat (8) @(posedge sys_clk_i);
      #2 rst_i = 1'b0;
      check("latch_a", latch_a_o, exp_a);
      check("latch_b", latch_b_o, exp_b);
      send(1'b0, 12'habc, 1'b0);
      send(1'b1, 12'h123, 1'b0);
      send(1'b0, 12'hf0f, 1'b1);
      send(1'b1, 12'h801, 1'b1);
      send(1'b0, 12'h5a5, 1'b0);
      @(posedge sys_clk_i) #2;
      clear_i = 1'b1;
      repeat (10) @(posedge sys_clk_i);
      #2 clear_i = 1'b0;
      exp_a = 12'h000;
      exp_b = 12'h000;
      check("latch_a", latch_a_o, exp_a);
      check("latch_b", latch_b_o, exp_b);
      send(1'b1, 12'h7e7, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
